// *** verilog/diag_cmd_defs.vh ***
`ifndef DIAG_CMD_DEFS_VH
`define DIAG_CMD_DEFS_VH

// APB register byte addresses
`define REG_CMD 8'h00
`define REG_FRAME_OUT 8'h04
`define REG_PENDING 8'h08
`define REG_STATUS_WORD 8'h0c
`define REG_IRQ_STATUS 8'h10
`define REG_IRQ_CLEAR 8'h14
`define REG_IRQ_ENABLE 8'h18
`define REG_OUT_CTRL 8'h1c
`define REG_DIAG_SEL 8'h20

// Command field positions
`define CMD_OP_HI 11
`define CMD_OP_LO 8
`define CMD_ARG_HI 7
`define CMD_ARG_LO 0

// Upper command nibbles
`define OP_READ_A 4'h5
`define OP_READ_B 4'h6
`define OP_CLEAR_A 4'h1
`define OP_CLEAR_B 4'h2
`define OP_CLEAR_ALL 4'h8
`define OP_MODE_ONE 4'hb
`define OP_MODE_TWO 4'hd
`define OP_MODE_THREE 4'he

// Interrupt bit positions
`define IRQ_COMM_ERR 0
`define IRQ_NEW_A 1
`define IRQ_NEW_B 2
`define IRQ_CMD_DONE 3

// Short status word bit positions
`define SDS_FAULT_A 0
`define SDS_FAULT_B 1
`define SDS_COMM_ERR 5

// Reset values
`define RST_INPUT_SEL 4'hf
`define RST_SERIAL_ON 4'h0
`define RST_DIAG_SEL 2'h1

`endif

// *** verilog/diag_bank_store.v ***
`timescale 1ns/100ps
module diag_bank_store (
  input wire pclk,
  input wire presetn,
  input wire [11:0] fault_a,
  input wire [11:0] fault_b,
  input wire clr_a,
  input wire clr_b,
  output reg [11:0] bank_a_r,
  output reg [11:0] bank_b_r,
  output reg new_a_r,
  output reg new_b_r
);

  reg [11:0] bank_a_nxt;
  reg [11:0] bank_b_nxt;

  // A clear reloads the faults still present, so a live fault survives it
  always @* begin
    if (clr_a) begin
      bank_a_nxt = fault_a;
    end else begin
      bank_a_nxt = bank_a_r | fault_a;
    end
    if (clr_b) begin
      bank_b_nxt = fault_b;
    end else begin
      bank_b_nxt = bank_b_r | fault_b;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_a_r <= 12'h000;
      bank_b_r <= 12'h000;
      new_a_r <= 1'b0;
      new_b_r <= 1'b0;
    end else begin
      bank_a_r <= bank_a_nxt;
      bank_b_r <= bank_b_nxt;
      new_a_r <= |(bank_a_nxt & ~bank_a_r);
      new_b_r <= |(bank_b_nxt & ~bank_b_r);
    end
  end

endmodule

// *** verilog/diag_clear_mode_cmd_decoder.v ***
`timescale 1ns/100ps
`include "diag_cmd_defs.vh"
module diag_clear_mode_cmd_decoder (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  input wire [11:0] fault_a,
  input wire [11:0] fault_b,
  input wire [7:0] virt_diag_in,
  input wire [3:0] parallel_input_pin,
  output reg [3:0] channel_drive,
  output wire irq
);

  localparam [3:0] C_NONE = 4'h0;
  localparam [3:0] C_READ_A = 4'h1;
  localparam [3:0] C_READ_B = 4'h2;
  localparam [3:0] C_CLEAR_A = 4'h3;
  localparam [3:0] C_CLEAR_B = 4'h4;
  localparam [3:0] C_CLEAR_ALL = 4'h5;
  localparam [3:0] C_MODE_ONE = 4'h6;
  localparam [3:0] C_MODE_TWO = 4'h7;
  localparam [3:0] C_MODE_THREE = 4'h8;
  localparam [3:0] C_BAD = 4'h9;

  reg [15:0] frame_out_r;
  reg [15:0] frame_out_nxt;
  reg [15:0] pending_r;
  reg [15:0] pending_nxt;
  reg [3:0] input_sel_r;
  reg [3:0] input_sel_nxt;
  reg [3:0] serial_on_r;
  reg [3:0] serial_on_nxt;
  reg [1:0] diag_sel_r;
  reg [1:0] diag_sel_nxt;
  reg [7:0] virt_diag_r;
  reg [7:0] virt_diag_nxt;
  reg [3:0] irq_status_r;
  reg [3:0] irq_status_nxt;
  reg [3:0] irq_enable_r;
  reg [3:0] irq_enable_nxt;
  reg [3:0] channel_drive_nxt;
  reg [31:0] prdata_nxt;
  reg pslverr_nxt;
  reg [3:0] irq_set;
  reg [3:0] irq_clr;
  reg [3:0] cmd_kind;
  reg clr_a;
  reg clr_b;
  wire [11:0] bank_a_r;
  wire [11:0] bank_b_r;
  wire new_a;
  wire new_b;
  wire setup_phase;
  wire wr_done;
  wire cmd_write;
  wire cmd_valid;
  wire bad_cmd;
  wire clear_write;
  wire enable_write;
  wire [7:0] sel_view;
  wire [11:0] cmd_word;
  wire [7:0] pin_set;
  wire [7:0] pin_feedback;
  wire [7:0] short_status_word;

  // Clear-all and mode commands decode on the upper nibble; the rest need a zero low byte
  function [3:0] decode_cmd;
    input [11:0] cmd;
    reg [3:0] op;
    reg low_zero;
    begin
      op = cmd[`CMD_OP_HI:`CMD_OP_LO];
      low_zero = (cmd[`CMD_ARG_HI:`CMD_ARG_LO] == 8'h00);
      if (op == `OP_READ_A && low_zero) begin
        decode_cmd = C_READ_A;
      end else if (op == `OP_READ_B && low_zero) begin
        decode_cmd = C_READ_B;
      end else if (op == `OP_CLEAR_A && low_zero) begin
        decode_cmd = C_CLEAR_A;
      end else if (op == `OP_CLEAR_B && low_zero) begin
        decode_cmd = C_CLEAR_B;
      end else if (op == `OP_CLEAR_ALL) begin
        decode_cmd = C_CLEAR_ALL;
      end else if (op == `OP_MODE_ONE) begin
        decode_cmd = C_MODE_ONE;
      end else if (op == `OP_MODE_TWO) begin
        decode_cmd = C_MODE_TWO;
      end else if (op == `OP_MODE_THREE) begin
        decode_cmd = C_MODE_THREE;
      end else begin
        decode_cmd = C_BAD;
      end
    end
  endfunction

  // Byte views of the two banks used as the three selectable registers
  function [7:0] diag_view;
    input [1:0] sel;
    input [11:0] ba;
    input [11:0] bb;
    begin
      if (sel == 2'h1) begin
        diag_view = ba[7:0];
      end else if (sel == 2'h2) begin
        diag_view = {bb[3:0], ba[11:8]};
      end else begin
        diag_view = bb[11:4];
      end
    end
  endfunction

  assign setup_phase = psel && !penable;
  assign pready = psel && penable;
  assign wr_done = psel && penable && pwrite;
  assign cmd_write = wr_done && (paddr == `REG_CMD);
  // Bad patterns leave every setting alone and only raise the error flag
  assign cmd_valid = (cmd_kind != C_NONE) && (cmd_kind != C_BAD);
  assign bad_cmd = (cmd_kind == C_BAD);
  assign clear_write = wr_done && (paddr == `REG_IRQ_CLEAR);
  assign enable_write = wr_done && (paddr == `REG_IRQ_ENABLE);
  assign sel_view = diag_view(diag_sel_r, bank_a_r, bank_b_r);
  assign cmd_word = pwdata[11:0];
  assign pin_set = cmd_word[`CMD_ARG_HI:`CMD_ARG_LO];
  assign pin_feedback = {channel_drive, input_sel_r};
  assign short_status_word = {2'h0, irq_status_r[`IRQ_COMM_ERR], 3'h0,
                              |bank_b_r, |bank_a_r};
  assign irq = |(irq_status_r & irq_enable_r);

  diag_bank_store u_banks (
    .pclk(pclk),
    .presetn(presetn),
    .fault_a(fault_a),
    .fault_b(fault_b),
    .clr_a(clr_a),
    .clr_b(clr_b),
    .bank_a_r(bank_a_r),
    .bank_b_r(bank_b_r),
    .new_a_r(new_a),
    .new_b_r(new_b)
  );

  always @* begin
    if (cmd_write) begin
      cmd_kind = decode_cmd(cmd_word);
    end else begin
      cmd_kind = C_NONE;
    end
  end

  // Command effects; the word shifted out now is the previous pending word, with its low byte replaced by a register view for clear-all and mode commands
  always @* begin
    frame_out_nxt = frame_out_r;
    pending_nxt = pending_r;
    input_sel_nxt = input_sel_r;
    serial_on_nxt = serial_on_r;
    diag_sel_nxt = diag_sel_r;
    virt_diag_nxt = virt_diag_r | virt_diag_in;
    clr_a = 1'b0;
    clr_b = 1'b0;
    if (cmd_valid) begin
      frame_out_nxt = pending_r;
    end
    case (cmd_kind)
      C_READ_A: begin
        pending_nxt = {4'h0, bank_a_r};
      end
      C_READ_B: begin
        pending_nxt = {4'h0, bank_b_r};
      end
      C_CLEAR_A: begin
        pending_nxt = {4'h0, bank_a_r};
        clr_a = 1'b1;
      end
      C_CLEAR_B: begin
        pending_nxt = {4'h0, bank_b_r};
        clr_b = 1'b1;
      end
      C_CLEAR_ALL: begin
        clr_a = 1'b1;
        clr_b = 1'b1;
        virt_diag_nxt = virt_diag_in;
        // Register two as it reads once the clear has re-latched live faults
        frame_out_nxt[7:0] = diag_view(2'h2, fault_a, fault_b);
        pending_nxt = {pin_feedback, 8'h00};
        input_sel_nxt = pin_set[3:0];
        serial_on_nxt = pin_set[7:4];
      end
      C_MODE_ONE: begin
        diag_sel_nxt = 2'h1;
        frame_out_nxt[7:0] = diag_view(2'h1, bank_a_r, bank_b_r);
        pending_nxt = {pin_feedback, 8'h00};
        input_sel_nxt = pin_set[3:0];
        serial_on_nxt = pin_set[7:4];
      end
      C_MODE_TWO: begin
        diag_sel_nxt = 2'h2;
        frame_out_nxt[7:0] = diag_view(2'h2, bank_a_r, bank_b_r);
        pending_nxt = {pin_feedback, 8'h00};
        input_sel_nxt = pin_set[3:0];
        serial_on_nxt = pin_set[7:4];
      end
      C_MODE_THREE: begin
        diag_sel_nxt = 2'h3;
        frame_out_nxt[7:0] = diag_view(2'h3, bank_a_r, bank_b_r);
        pending_nxt = {pin_feedback, 8'h00};
        input_sel_nxt = pin_set[3:0];
        serial_on_nxt = pin_set[7:4];
      end
      default: begin
        frame_out_nxt = frame_out_r;
      end
    endcase
  end

  // Interrupt flags: a new event wins over a clear in the same cycle
  always @* begin
    irq_set = 4'h0;
    irq_set[`IRQ_COMM_ERR] = bad_cmd;
    irq_set[`IRQ_NEW_A] = new_a;
    irq_set[`IRQ_NEW_B] = new_b;
    irq_set[`IRQ_CMD_DONE] = cmd_valid;
    irq_clr = 4'h0;
    if (clear_write) begin
      irq_clr = pwdata[3:0];
    end
    irq_status_nxt = (irq_status_r & ~irq_clr) | irq_set;
  end

  // Enable register keeps its value unless software writes it
  always @* begin
    irq_enable_nxt = irq_enable_r;
    if (enable_write) begin
      irq_enable_nxt = pwdata[3:0];
    end
  end

  // Parallel-selected channels follow their pin, the serial bit is ignored
  always @* begin
    channel_drive_nxt = (input_sel_r & parallel_input_pin) |
                        (~input_sel_r & serial_on_r);
  end

  // Registered so the pins never glitch while the settings change
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_drive <= 4'h0;
    end else begin
      channel_drive <= channel_drive_nxt;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_out_r <= 16'h0000;
      pending_r <= 16'h0000;
      input_sel_r <= `RST_INPUT_SEL;
      serial_on_r <= `RST_SERIAL_ON;
      diag_sel_r <= `RST_DIAG_SEL;
      virt_diag_r <= 8'h00;
      irq_status_r <= 4'h0;
      irq_enable_r <= 4'h0;
    end else begin
      frame_out_r <= frame_out_nxt;
      pending_r <= pending_nxt;
      input_sel_r <= input_sel_nxt;
      serial_on_r <= serial_on_nxt;
      diag_sel_r <= diag_sel_nxt;
      virt_diag_r <= virt_diag_nxt;
      irq_status_r <= irq_status_nxt;
      irq_enable_r <= irq_enable_nxt;
    end
  end

  // Write-only and read-only registers refuse the other direction
  always @* begin
    prdata_nxt = 32'h00000000;
    pslverr_nxt = 1'b0;
    if (paddr == `REG_CMD) begin
      pslverr_nxt = !pwrite;
    end else if (paddr == `REG_FRAME_OUT) begin
      prdata_nxt = {16'h0000, frame_out_r};
      pslverr_nxt = pwrite;
    end else if (paddr == `REG_PENDING) begin
      prdata_nxt = {16'h0000, pending_r};
      pslverr_nxt = pwrite;
    end else if (paddr == `REG_STATUS_WORD) begin
      prdata_nxt = {24'h000000, short_status_word};
      pslverr_nxt = pwrite;
    end else if (paddr == `REG_IRQ_STATUS) begin
      prdata_nxt = {28'h0000000, irq_status_r};
      pslverr_nxt = pwrite;
    end else if (paddr == `REG_IRQ_CLEAR) begin
      pslverr_nxt = !pwrite;
    end else if (paddr == `REG_IRQ_ENABLE) begin
      prdata_nxt = {28'h0000000, irq_enable_r};
    end else if (paddr == `REG_OUT_CTRL) begin
      prdata_nxt = {8'h00, virt_diag_r, channel_drive, diag_sel_r, 2'h0,
                    serial_on_r, input_sel_r};
      pslverr_nxt = pwrite;
    end else if (paddr == `REG_DIAG_SEL) begin
      prdata_nxt = {22'h000000, diag_sel_r, sel_view};
      pslverr_nxt = pwrite;
    end else begin
      pslverr_nxt = 1'b1;
    end
  end

  // Read data is captured in the setup cycle, so no wait state is needed
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      prdata <= prdata_nxt;
      pslverr <= pslverr_nxt;
    end
  end

endmodule

// *** verif/diag_cmd_properties.sv ***
`timescale 1ns/100ps
`include "diag_cmd_defs.vh"
module diag_cmd_properties (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [11:0] fault_a,
  input wire [11:0] fault_b,
  input wire [7:0] virt_diag_in,
  input wire [3:0] parallel_input_pin,
  input wire [3:0] channel_drive,
  input wire irq
);
  reg [3:0] sel_r;
  reg [3:0] on_r;
  reg en0_r;
  wire [3:0] op = pwdata[11:8];
  wire acc = psel && penable;
  wire setup = psel && !penable;
  wire wr_cmd = acc && pwrite && paddr == `REG_CMD;
  wire mode = op == 4'h8 || op == 4'hb || op == 4'hd || op == 4'he;
  wire plain = (op == 4'h5 || op == 4'h6 || op == 4'h1 || op == 4'h2) && pwdata[7:0] == 8'h00;
  wire [3:0] drive = (parallel_input_pin & sel_r) | (on_r & ~sel_r);
  // Shadow of the pin settings, rebuilt from the command writes alone
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_r <= 4'hf;
      on_r <= 4'h0;
      en0_r <= 1'b0;
    end else begin
      if (wr_cmd && mode) begin
        sel_r <= pwdata[3:0];
        on_r <= pwdata[7:4];
      end
      if (acc && pwrite && paddr == `REG_IRQ_ENABLE) begin
        en0_r <= pwdata[0];
      end
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_now: assert property (pready == acc) else $error("pready not tied to access");
  a_err_unmapped: assert property (setup && (paddr > `REG_DIAG_SEL || paddr[1:0] != 2'h0)
    |=> pslverr) else $error("unmapped address not refused");
  a_err_cmd_read: assert property (setup && !pwrite && paddr == `REG_CMD |=> pslverr)
    else $error("read of command register not refused");
  a_data_stands: assert property (!setup |=> $stable({prdata, pslverr}))
    else $error("read answer moved outside setup");
  a_drive_follow: assert property ($past(presetn) |-> channel_drive == $past(drive))
    else $error("channel drive does not follow settings");
  a_ctrl_view: assert property (setup && !pwrite && paddr == `REG_OUT_CTRL
    |=> prdata[7:0] == $past({on_r, sel_r}) && prdata[15:12] == $past(channel_drive))
    else $error("output control view wrong");
  a_irq_mask: assert property (acc && pwrite && paddr == `REG_IRQ_ENABLE && pwdata == 32'h0
    |=> !irq) else $error("masked interrupt still high");
  a_invalid_irq: assert property (wr_cmd && !(mode || plain) && en0_r |=> irq)
    else $error("invalid command raised no interrupt");
  c_mode: cover property (wr_cmd && mode);
  c_invalid: cover property (wr_cmd && !(mode || plain));
  c_unmapped: cover property (setup && paddr > `REG_DIAG_SEL);
endmodule
bind diag_clear_mode_cmd_decoder diag_cmd_properties diag_cmd_properties_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .fault_a(fault_a), .fault_b(fault_b), .virt_diag_in(virt_diag_in),
  .parallel_input_pin(parallel_input_pin), .channel_drive(channel_drive), .irq(irq));

// *** verif/fault_env.sv ***
`timescale 1ns/100ps
module fault_env (
  input wire pclk,
  output reg [11:0] fault_a,
  output reg [11:0] fault_b,
  output reg [7:0] virt_diag_in,
  output reg [3:0] parallel_input_pin
);
  initial begin
    fault_a = 12'h000;
    fault_b = 12'h000;
    virt_diag_in = 8'h00;
    parallel_input_pin = 4'h0;
  end
  task set_pins(input [3:0] p);
    begin
      @(posedge pclk);
      parallel_input_pin <= p;
    end
  endtask
  // Events last one cycle so that only the sticky latch can keep them
  task pulse(input [11:0] a, input [11:0] b, input [11:0] hold, input [7:0] v);
    begin
      @(posedge pclk);
      fault_a <= a | hold;
      fault_b <= b;
      virt_diag_in <= v;
      @(posedge pclk);
      fault_a <= hold;
      fault_b <= 12'h000;
      virt_diag_in <= 8'h00;
    end
  endtask
endmodule

// *** verif/testbench.sv ***
`timescale 1ns/100ps
`include "diag_cmd_defs.vh"
module testbench;
  reg pclk;
  reg presetn;
  reg psel;
  reg penable;
  reg pwrite;
  reg [7:0] paddr;
  reg [31:0] pwdata;
  reg [31:0] rd;
  reg err;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire [11:0] fault_a;
  wire [11:0] fault_b;
  wire [7:0] virt_diag_in;
  wire [3:0] parallel_input_pin;
  wire [3:0] channel_drive;
  wire irq;
  integer n_mismatch;
  integer n_checks;
  diag_clear_mode_cmd_decoder diag_clear_mode_cmd_decoder_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fault_a(fault_a), .fault_b(fault_b), .virt_diag_in(virt_diag_in),
    .parallel_input_pin(parallel_input_pin), .channel_drive(channel_drive), .irq(irq));
  fault_env fault_env_i (.pclk(pclk), .fault_a(fault_a), .fault_b(fault_b),
    .virt_diag_in(virt_diag_in), .parallel_input_pin(parallel_input_pin));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task check(input [63:0] nm, input [31:0] seen, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("wrong value %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
    integer t;
    begin
      t = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && t < 20) begin
        t = t + 1;
        @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task rdchk(input [63:0] nm, input [7:0] a, input [31:0] exp);
    begin
      apb(1'b0, a, 32'h0);
      check(nm, rd, exp);
    end
  endtask
  task cmd(input [11:0] c, input [31:0] exp);
    begin
      apb(1'b1, `REG_CMD, {20'h0, c});
      rdchk("frame", `REG_FRAME_OUT, exp);
    end
  endtask
  initial begin
    #400000;
    n_mismatch = n_mismatch + 1;
    print_verdict;
  end
  initial begin
    n_mismatch = 0;
    n_checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("ctrl", `REG_OUT_CTRL, 32'h0000040f);
    fault_env_i.set_pins(4'h6);
    fault_env_i.pulse(12'h0a5, 12'h300, 12'h800, 8'h00);
    apb(1'b1, `REG_CMD, 32'h500);
    cmd(12'h600, 32'h8a5);
    cmd(12'h100, 32'h300);
    cmd(12'h600, 32'h8a5);
    cmd(12'h500, 32'h300);
    cmd(12'h200, 32'h800);
    cmd(12'h600, 32'h300);
    cmd(12'h500, 32'h000);
    cmd(12'hb05, 32'h0800);
    rdchk("ctrl", `REG_OUT_CTRL, 32'h4405);
    cmd(12'hda2, 32'h6f08);
    rdchk("ctrl", `REG_OUT_CTRL, 32'ha8a2);
    check("drive", {28'h0, channel_drive}, 32'ha);
    fault_env_i.pulse(12'h000, 12'h030, 12'h800, 8'h11);
    cmd(12'hef0, 32'h4503);
    rdchk("ctrl", `REG_OUT_CTRL, 32'h11fcf0);
    rdchk("diagsel", `REG_DIAG_SEL, 32'h303);
    cmd(12'h80f, 32'ha208);
    apb(1'b0, `REG_OUT_CTRL, 32'h0);
    check("virt", {24'h0, rd[23:16]}, 32'h0);
    cmd(12'h600, 32'hf000);
    cmd(12'h500, 32'h000);
    cmd(12'h500, 32'h800);
    apb(1'b1, `REG_IRQ_ENABLE, 32'h1);
    apb(1'b1, `REG_IRQ_CLEAR, 32'hf);
    apb(1'b1, `REG_CMD, 32'h501);
    repeat (2) @(posedge pclk);
    check("irq", {31'h0, irq}, 32'h1);
    rdchk("status", `REG_STATUS_WORD, 32'h21);
    rdchk("irqstat", `REG_IRQ_STATUS, 32'h1);
    cmd(12'h600, 32'h800);
    apb(1'b1, `REG_IRQ_ENABLE, 32'h0);
    @(posedge pclk);
    check("irq", {31'h0, irq}, 32'h0);
    apb(1'b1, `REG_IRQ_ENABLE, 32'h1);
    apb(1'b1, `REG_IRQ_CLEAR, 32'h1);
    @(posedge pclk);
    check("irq", {31'h0, irq}, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    check("err", {31'h0, err}, 32'h1);
    apb(1'b0, `REG_CMD, 32'h0);
    check("err", {31'h0, err}, 32'h1);
    print_verdict;
  end
endmodule
